// >>> src/wdw_top.sv
// Windowed watchdog: control register, counter, window check, Avalon slave
// How it works
// - Period select 10 overflows after 2^22 gear or 2^15 slow periods.
// - Period select 11 overflows after 2^24 gear or 2^17 slow periods.
// - Gear clock times unless divider select is 1 or slow mode.
// - Action bit 0 turns overflow into an interrupt, not a reset.
// - Window 10: early clear raises interrupt; clear allowed after half.
// - Window 11: clear allowed after three quarters, earlier interrupts.
// - While enabled, window, period and action fields ignore writes.
// - The write that sets enable from 0 to 1 loads new fields.
// - Control reads show bit 7 as 1 and bit 6 as 0.
// - Period select 00 overflows after 2^18 gear or 2^11 slow periods.
// - Clear code restarts the counter when inside the window.
// - Disable code with enable 0 stops and zeroes the counter.
// - Overflow raises reset or interrupt request per action bit.
//
// Design decisions made here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module wdw_top #(
  parameter int GEAR_DIV_LOG2 = wdw_pkg::GEAR_OVF_LOG2 - wdw_pkg::CNT_LOG2,
  parameter int LF_DIV_LOG2   = wdw_pkg::LF_OVF_LOG2 - wdw_pkg::CNT_LOG2,
  parameter int PRE_W         = 16
) (
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  input  wire logic        low_frequency_clock_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             irq_o,
  output logic             wdt_reset_req_o
);
  import wdw_pkg::*;

  if (GEAR_DIV_LOG2 < 1 || LF_DIV_LOG2 < 1) begin : g_chk
    $error("wdw_top: divider exponents must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic        wait_q;
  logic [31:0] rdata_q;
  logic        en_q;
  logic        act_q;
  logic [1:0]  per_q;
  logic [1:0]  win_q;
  logic        div_sel_q;
  logic        slow_q;
  logic        running_q;
  logic [7:0]  cnt_q;
  logic [1:0]  sts_q;
  logic [1:0]  mask_q;
  logic        irq_q;
  logic        rst_req_q;
  logic        req;
  logic        wr_done;
  logic        ctrl_wr;
  logic        code_wr;
  logic        sts_wr;
  logic [7:0]  wbyte;
  logic        use_lf;
  logic        lf_rise;
  logic        tick;
  logic        clear_try;
  logic        clear_ok;
  logic        clear_early;
  logic        dis_hit;
  logic        start_hit;
  logic        ovf_evt;
  logic [1:0]  sts_set;
  logic [31:0] rd_mux;

  // Clear is open once the count has reached the window's start
  function automatic logic win_open(input logic [1:0] w, input logic [7:0] c);
    unique case (w)
      WIN_HALF_SEL: win_open = c >= WIN_HALF_CNT;
      WIN_3Q_SEL:   win_open = c >= WIN_3Q_CNT;
      default:      win_open = 1'h1;
    endcase
  endfunction

  function automatic logic [7:0] ctrl_image(input logic e, input logic a,
                                            input logic [1:0] p,
                                            input logic [1:0] w);
    logic [7:0] v;
    v = '0;
    v[CTRL_EN_BIT] = e;
    v[CTRL_ACT_BIT] = a;
    v[CTRL_PER_LSB +: 2] = p;
    v[CTRL_WIN_LSB +: 2] = w;
    v[CTRL_FIX_LSB +: 2] = CTRL_FIXED;
    ctrl_image = v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then the access completes

  assign req     = avs_read_i || avs_write_i;
  assign wr_done = avs_write_i && !wait_q && avs_byteenable_i[0];
  assign wbyte   = avs_writedata_i[7:0];
  assign ctrl_wr = wr_done && (avs_address_i == ADDR_CTRL);
  assign code_wr = wr_done && (avs_address_i == ADDR_CODE);
  assign sts_wr  = wr_done && (avs_address_i == ADDR_STS);

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wait_q <= 1'h1;
    end else begin
      wait_q <= !(req && wait_q);
    end
  end

  always_comb begin
    rd_mux = '0;
    unique case (avs_address_i)
      ADDR_CTRL: rd_mux[7:0] = ctrl_image(en_q, act_q, per_q, win_q);
      ADDR_CNT:  rd_mux[7:0] = cnt_q;
      ADDR_STS:  begin
        rd_mux[1:0]         = sts_q;
        rd_mux[STS_RUN_BIT] = running_q;
      end
      ADDR_MASK: rd_mux[1:0] = mask_q;
      ADDR_CFG:  begin
        rd_mux[CFG_DIV_BIT]  = div_sel_q;
        rd_mux[CFG_SLOW_BIT] = slow_q;
      end
      default:   rd_mux = '0;
    endcase
  end

  // Data is captured on the waiting cycle and holds through completion
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rdata_q <= '0;
    end else if (avs_read_i && wait_q) begin
      rdata_q <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and configuration registers

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      en_q  <= CTRL_EN_RST;
      act_q <= CTRL_ACT_RST;
      per_q <= CTRL_PER_RST;
      win_q <= CTRL_WIN_RST;
    end else if (ctrl_wr) begin
      en_q <= wbyte[CTRL_EN_BIT];
      // Fields load only while enable is 0, including the enabling write
      if (!en_q) begin
        act_q <= wbyte[CTRL_ACT_BIT];
        per_q <= wbyte[CTRL_PER_LSB +: 2];
        win_q <= wbyte[CTRL_WIN_LSB +: 2];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      div_sel_q <= 1'h0;
      slow_q    <= 1'h0;
      mask_q    <= '0;
    end else if (wr_done && avs_address_i == ADDR_CFG) begin
      div_sel_q <= wbyte[CFG_DIV_BIT];
      slow_q    <= wbyte[CFG_SLOW_BIT];
    end else if (wr_done && avs_address_i == ADDR_MASK) begin
      mask_q <= wbyte[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counting source and prescaler

  assign use_lf = div_sel_q || slow_q;

  wdw_sync u_lf_sync (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .async_i   (low_frequency_clock_i),
    .rise_o    (lf_rise)
  );

  wdw_prescaler #(
    .W         (PRE_W),
    .GEAR_LOG2 (GEAR_DIV_LOG2),
    .LF_LOG2   (LF_DIV_LOG2)
  ) u_pre (
    .ref_clk_i    (ref_clk_i),
    .srst_i       (srst_i),
    .restart_i    (clear_ok || dis_hit || start_hit),
    .run_i        (running_q),
    .use_lf_i     (use_lf),
    .lf_rise_i    (lf_rise),
    .period_sel_i (per_q),
    .tick_o       (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counter, codes and events

  assign clear_try   = code_wr && (wbyte == CODE_CLEAR) && running_q;
  assign clear_ok    = clear_try && win_open(win_q, cnt_q);
  assign clear_early = clear_try && !clear_ok;
  // Disable needs enable already cleared by software
  assign dis_hit     = code_wr && (wbyte == CODE_DISABLE) && !en_q;
  assign start_hit   = ctrl_wr && wbyte[CTRL_EN_BIT] && !running_q;
  // Disable wins over an overflow in the same cycle
  assign ovf_evt     = running_q && tick && (cnt_q == CNT_MAX) && !dis_hit;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      running_q <= CTRL_EN_RST;
    end else if (dis_hit) begin
      running_q <= 1'h0;
    end else if (start_hit) begin
      running_q <= 1'h1;
    end
  end

  // Counting wraps past overflow and continues for either action
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || dis_hit || !running_q || clear_ok) begin
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  always_comb begin
    sts_set              = '0;
    sts_set[STS_OVF_BIT] = ovf_evt && !act_q;
    sts_set[STS_WIN_BIT] = clear_early;
  end

  // Set beats a same-cycle write-one clear
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sts_q <= '0;
    end else begin
      sts_q <= (sts_q & ~(sts_wr ? wbyte[1:0] : 2'h0)) | sts_set;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      irq_q     <= 1'h0;
      rst_req_q <= 1'h0;
    end else begin
      irq_q     <= |(sts_q & mask_q);
      rst_req_q <= ovf_evt && act_q;
    end
  end

  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign irq_o             = irq_q;
  assign wdt_reset_req_o   = rst_req_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  // Gap between gear-clock ticks under an unchanged setup
  logic [31:0] gap_q;
  logic        clean_q;
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || tick || !running_q) begin
      gap_q <= '0;
    end else begin
      gap_q <= gap_q + 32'd1;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || use_lf || ctrl_wr || clear_ok || start_hit) begin
      clean_q <= 1'h0;
    end else if (tick) begin
      clean_q <= 1'h1;
    end
  end

  property p_lock;
    ctrl_wr && en_q |=> $stable(per_q) && $stable(win_q) && $stable(act_q);
  endproperty
  a_lock: assert property (p_lock) else $error("locked field changed");

  property p_load;
    ctrl_wr && !en_q && wbyte[CTRL_EN_BIT]
      |=> per_q == $past(wbyte[CTRL_PER_LSB +: 2]) && en_q;
  endproperty
  a_load: assert property (p_load) else $error("enable write lost fields");

  property p_fixed;
    avs_read_i && !wait_q && avs_address_i == ADDR_CTRL
      |-> avs_readdata_o[7:6] == CTRL_FIXED;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed bits wrong");
  // The mask may move under the interrupt, so the one in force is used
  property p_ovf_irq;
    ovf_evt && !act_q |=> (sts_q[STS_OVF_BIT] && !wdt_reset_req_o)
      ##1 (irq_o || !$past(mask_q[STS_OVF_BIT]));
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq wrong");
  property p_ovf_rst;
    ovf_evt && act_q |=> wdt_reset_req_o ##1 !wdt_reset_req_o;
  endproperty
  a_ovf_rst: assert property (p_ovf_rst) else $error("no reset pulse");
  property p_half;
    clear_try && win_q == WIN_HALF_SEL && cnt_q < WIN_HALF_CNT
      |=> sts_q[STS_WIN_BIT] && (cnt_q != 8'h00 || $past(cnt_q) == 8'h00);
  endproperty
  a_half: assert property (p_half) else $error("half window missed");
  property p_3q;
    clear_try && win_q == WIN_3Q_SEL && cnt_q < WIN_3Q_CNT |=> sts_q[STS_WIN_BIT];
  endproperty
  a_3q: assert property (p_3q) else $error("3/4 window missed");
  property p_clear;
    clear_try && cnt_q >= WIN_3Q_CNT
      |-> !sts_set[STS_WIN_BIT] ##1 cnt_q == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("clear not taken");
  property p_dis;
    dis_hit |=> !running_q && cnt_q == 8'h00 ##1 cnt_q == 8'h00;
  endproperty
  a_dis: assert property (p_dis) else $error("disable failed");

  property p_gap;
    tick && clean_q && !use_lf
      |-> gap_q + 32'd1 == 32'd1 << (GEAR_DIV_LOG2 + SEL_STEP_LOG2 * int'(per_q));
  endproperty
  a_gap: assert property (p_gap) else $error("tick spacing wrong");

endmodule // wdw_top
`default_nettype wire

// >>> src/wdw_pkg.sv
// Constants shared by the windowed watchdog configuration block
package wdw_pkg;

  // Register byte addresses on the Avalon-MM slave
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_CODE = 5'h04;
  localparam logic [4:0] ADDR_CNT  = 5'h08;
  localparam logic [4:0] ADDR_STS  = 5'h0C;
  localparam logic [4:0] ADDR_MASK = 5'h10;
  localparam logic [4:0] ADDR_CFG  = 5'h14;

  // Control register field positions
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_ACT_BIT = 1;
  localparam int CTRL_PER_LSB = 2;
  localparam int CTRL_WIN_LSB = 4;
  localparam int CTRL_FIX_LSB = 6;
  localparam logic [1:0] CTRL_FIXED = 2'h2;

  // Control register reset values
  localparam logic       CTRL_EN_RST  = 1'h1;
  localparam logic       CTRL_ACT_RST = 1'h1;
  localparam logic [1:0] CTRL_PER_RST = 2'h3;
  localparam logic [1:0] CTRL_WIN_RST = 2'h0;

  // Code register values
  localparam logic [7:0] CODE_CLEAR   = 8'h4E;
  localparam logic [7:0] CODE_DISABLE = 8'hB1;

  // Clear-window encodings and the counts at which a clear opens
  localparam logic [1:0] WIN_HALF_SEL = 2'h2;
  localparam logic [1:0] WIN_3Q_SEL   = 2'h3;
  localparam logic [7:0] WIN_HALF_CNT = 8'h80;
  localparam logic [7:0] WIN_3Q_CNT   = 8'hC0;
  localparam logic [7:0] CNT_MAX      = 8'hFF;

  // Overflow periods as log2 of source periods, for select 00
  localparam int GEAR_OVF_LOG2 = 18;
  localparam int LF_OVF_LOG2   = 11;
  localparam int CNT_LOG2      = 8;
  localparam int SEL_STEP_LOG2 = 2;

  // Status and configuration bit positions
  localparam int STS_OVF_BIT  = 0;
  localparam int STS_WIN_BIT  = 1;
  localparam int STS_RUN_BIT  = 2;
  localparam int CFG_DIV_BIT  = 0;
  localparam int CFG_SLOW_BIT = 1;

endpackage

// >>> src/wdw_sync.sv
// Three-stage synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/100ps
`default_nettype none
module wdw_sync (
  input  wire logic ref_clk_i,
  input  wire logic srst_i,
  input  wire logic async_i,
  output logic      rise_o
);
  logic meta_q;
  logic sync_q;
  logic late_q;
  logic level_q;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      meta_q <= 1'h0;
      sync_q <= 1'h0;
      late_q <= 1'h0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
      late_q <= sync_q;
    end
  end

  // A change counts only once the two late stages agree
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      level_q <= 1'h0;
    end else if (sync_q == late_q) begin
      level_q <= late_q;
    end
  end

  assign rise_o = (sync_q == late_q) && late_q && !level_q;
endmodule // wdw_sync
`default_nettype wire

// >>> src/wdw_prescaler.sv
// Prescaler producing the 8-bit counter's increment tick
`timescale 1ns/100ps
`default_nettype none
module wdw_prescaler #(
  parameter int W         = 16,
  parameter int GEAR_LOG2 = 10,
  parameter int LF_LOG2   = 3
) (
  input  wire logic       ref_clk_i,
  input  wire logic       srst_i,
  input  wire logic       restart_i,
  input  wire logic       run_i,
  input  wire logic       use_lf_i,
  input  wire logic       lf_rise_i,
  input  wire logic [1:0] period_sel_i,
  output logic            tick_o
);
  import wdw_pkg::*;

  if (GEAR_LOG2 + 3 * SEL_STEP_LOG2 > W || LF_LOG2 + 3 * SEL_STEP_LOG2 > W)
  begin : g_chk
    $error("wdw_prescaler: W too small for the longest period");
  end

  logic [W-1:0] cnt_q;
  logic [W-1:0] limit;
  logic         step;
  int           shift;

  always_comb begin
    // Gear clock ticks every cycle; the slow clock only on its rising edges
    step  = run_i && (use_lf_i ? lf_rise_i : 1'h1);
    // Each select step multiplies the period by four
    shift = (use_lf_i ? LF_LOG2 : GEAR_LOG2)
          + SEL_STEP_LOG2 * int'(period_sel_i);
    limit = W'((64'd1 << shift) - 64'd1);
    // Compare with >= so a source switch mid-count cannot skip a tick
    tick_o = step && (cnt_q >= limit);
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i || restart_i || !run_i) begin
      cnt_q <= '0;
    end else if (step) begin
      cnt_q <= tick_o ? '0 : cnt_q + W'(1);
    end
  end
endmodule // wdw_prescaler
`default_nettype wire

// >>> sim/wdw_top_tb_top.sv
// Self-checking testbench for the windowed watchdog configuration block
`timescale 1ns/100ps
`default_nettype none
module wdw_top_tb_top;
  import wdw_pkg::*;
  // Short prescaler so the slowest measured overflow stays near 16k cycles
  localparam int GL      = 2;
  localparam int LL      = 1;
  localparam int LF_HALF = 4;
  logic        ref_clk_i             = 1'b0;
  logic        srst_i                = 1'b1;
  logic        low_frequency_clock_i = 1'b0;
  logic [4:0]  avs_address_i         = 5'h00;
  logic        avs_read_i            = 1'b0;
  logic        avs_write_i           = 1'b0;
  logic [31:0] avs_writedata_i       = 32'h0;
  logic [3:0]  avs_byteenable_i      = 4'hF;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        irq_o;
  logic        wdt_reset_req_o;
  int          fail_count = 0;
  int          compares   = 0;
  int          lf_cnt     = 0;
  logic [31:0] lfsr_q     = 32'hC03B;
  logic [31:0] rd;

  always #12.5 ref_clk_i = ~ref_clk_i;

  // Slow source runs free, as a crystal would, with no relation to the bus
  always @(posedge ref_clk_i) begin
    lf_cnt <= (lf_cnt == LF_HALF - 1) ? 0 : lf_cnt + 1;
    if (lf_cnt == LF_HALF - 1) begin
      low_frequency_clock_i <= ~low_frequency_clock_i;
    end
  end

  wdw_top #(.GEAR_DIV_LOG2(GL), .LF_DIV_LOG2(LL), .PRE_W(16)) uut (
    .ref_clk_i             (ref_clk_i),
    .srst_i                (srst_i),
    .low_frequency_clock_i (low_frequency_clock_i),
    .avs_address_i         (avs_address_i),
    .avs_read_i            (avs_read_i),
    .avs_write_i           (avs_write_i),
    .avs_writedata_i       (avs_writedata_i),
    .avs_byteenable_i      (avs_byteenable_i),
    .avs_readdata_o        (avs_readdata_o),
    .avs_waitrequest_o     (avs_waitrequest_o),
    .irq_o                 (irq_o),
    .wdt_reset_req_o       (wdt_reset_req_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] exp_ctrl(input logic e, input logic a,
                                          input logic [1:0] p,
                                          input logic [1:0] w);
    return {1'b1, 1'b0, w, p, a, e};
  endfunction

  function automatic int exp_ovf(input int p, input logic lf);
    return lf ? (256 << (LL + 2 * p)) * 2 * LF_HALF : 256 << (GL + 2 * p);
  endfunction

  function automatic logic near(input int seen, input int exp, input int tol);
    return (seen <= exp + tol) && (seen + tol >= exp);
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Holds the request until waitrequest is sampled low, takes data there
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= {24'h0, d};
    avs_write_i     <= wr;
    avs_read_i      <= ~wr;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    chk("bus_answer", 32'(n < 50), 32'h1);
  endtask

  task automatic rdchk(input string nm, input logic [4:0] a,
                       input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(nm, rd, {24'h0, exp});
  endtask

  task automatic poll(input logic [7:0] thr);
    int n;
    n = 0;
    do begin
      bus(1'b0, ADDR_CNT, 8'h00);
      n++;
    end while (rd[7:0] < thr && n < 400);
  endtask

  task automatic restart(input logic [7:0] ctrl, input logic [7:0] cfg);
    bus(1'b1, ADDR_CTRL, 8'h00);
    bus(1'b1, ADDR_CODE, CODE_DISABLE);
    bus(1'b1, ADDR_STS, 8'h03);
    bus(1'b1, ADDR_CFG, cfg);
    bus(1'b1, ADDR_CTRL, ctrl);
  endtask

  task automatic ovf_time(input int p, input logic a, input logic [7:0] cfg);
    int n;
    int tol;
    n = 0;
    tol = (cfg != 8'h00) ? 24 : 8;
    restart(exp_ctrl(1'b1, a, 2'(p), 2'h0), cfg);
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (wdt_reset_req_o !== 1'b1 && irq_o !== 1'b1 && n < 20000);
    chk("ovf_time", 32'(near(n, exp_ovf(p, cfg != 8'h00), tol)),
        32'h1);
    chk("ovf_kind", {30'h0, wdt_reset_req_o, irq_o},
        a ? 32'h2 : 32'h1);
    $display("test overflow period %0d action %0d cfg %h done", p, a, cfg);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    rdchk("ctrl_reset", ADDR_CTRL,
          exp_ctrl(1'b1, 1'b1, 2'h3, 2'h0));
    bus(1'b1, 5'h18, 8'h5A);
    rdchk("unmapped", 5'h18, 8'h00);
    for (int i = 0; i < 6; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      bus(1'b1, ADDR_CTRL, lfsr_q[7:0] | 8'h01);
      rdchk("ctrl_locked", ADDR_CTRL,
            exp_ctrl(1'b1, 1'b1, 2'h3, 2'h0));
    end
    avs_byteenable_i <= 4'h0;
    bus(1'b1, ADDR_CTRL, 8'h00);
    avs_byteenable_i <= 4'hF;
    rdchk("ctrl_no_be", ADDR_CTRL, exp_ctrl(1'b1, 1'b1, 2'h3, 2'h0));
    bus(1'b1, ADDR_CTRL, 8'h30);
    rdchk("ctrl_en_off", ADDR_CTRL,
          exp_ctrl(1'b0, 1'b1, 2'h3, 2'h0));
    rdchk("still_runs", ADDR_STS, 8'h04);
    for (int i = 0; i < 4; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      if (lfsr_q[7:0] != CODE_CLEAR && lfsr_q[7:0] != CODE_DISABLE) begin
        bus(1'b1, ADDR_CODE, lfsr_q[7:0]);
        rdchk("bad_code", ADDR_STS, 8'h04);
      end
    end
    bus(1'b1, ADDR_CODE, CODE_DISABLE);
    rdchk("stopped", ADDR_STS, 8'h00);
    repeat (300) @(posedge ref_clk_i);
    rdchk("cnt_zero", ADDR_CNT, 8'h00);
    bus(1'b1, ADDR_CTRL, exp_ctrl(1'b1, 1'b0, 2'h1, 2'h1));
    rdchk("ctrl_load", ADDR_CTRL,
          exp_ctrl(1'b1, 1'b0, 2'h1, 2'h1));
    $display("test lock and disable done");
    // Period 11 is too long to reach overflow, so its tick rate is measured
    restart(exp_ctrl(1'b1, 1'b1, 2'h3, 2'h0), 8'h00);
    repeat (2560) @(posedge ref_clk_i);
    bus(1'b0, ADDR_CNT, 8'h00);
    chk("rate_p3", 32'(near(int'(rd), 10, 1)), 32'h1);
    bus(1'b1, ADDR_MASK, 8'h01);
    for (int p = 0; p < 3; p++) begin
      ovf_time(p, 1'b1, 8'h00);
    end
    ovf_time(0, 1'b1, 8'h01);
    ovf_time(0, 1'b1, 8'h02);
    ovf_time(0, 1'b0, 8'h00);
    rdchk("sts_ovf", ADDR_STS, 8'h05);
    bus(1'b1, ADDR_STS, 8'h01);
    rdchk("sts_w1c", ADDR_STS, 8'h04);
    chk("irq_clr", 32'(irq_o), 32'h0);
    // Window 10, with the early-clear interrupt first masked
    bus(1'b1, ADDR_MASK, 8'h00);
    restart(exp_ctrl(1'b1, 1'b0, 2'h0, WIN_HALF_SEL), 8'h00);
    bus(1'b1, ADDR_CODE, CODE_CLEAR);
    rdchk("early_half", ADDR_STS, 8'h06);
    chk("irq_masked", 32'(irq_o), 32'h0);
    bus(1'b1, ADDR_MASK, 8'h02);
    repeat (2) @(posedge ref_clk_i);
    chk("irq_unmasked", 32'(irq_o), 32'h1);
    bus(1'b1, ADDR_STS, 8'h02);
    repeat (2) @(posedge ref_clk_i);
    chk("irq_w1c", 32'(irq_o), 32'h0);
    poll(WIN_HALF_CNT);
    bus(1'b1, ADDR_CODE, CODE_CLEAR);
    bus(1'b0, ADDR_CNT, 8'h00);
    chk("clear_half", 32'(rd < 32'h8), 32'h1);
    rdchk("late_half", ADDR_STS, 8'h04);
    $display("test window half done");
    restart(exp_ctrl(1'b1, 1'b0, 2'h0, WIN_3Q_SEL), 8'h00);
    poll(WIN_HALF_CNT);
    bus(1'b1, ADDR_CODE, CODE_CLEAR);
    rdchk("early_3q", ADDR_STS, 8'h06);
    bus(1'b0, ADDR_CNT, 8'h00);
    chk("kept_3q", 32'(rd >= 32'h80), 32'h1);
    bus(1'b1, ADDR_STS, 8'h02);
    poll(WIN_3Q_CNT);
    bus(1'b1, ADDR_CODE, CODE_CLEAR);
    bus(1'b0, ADDR_CNT, 8'h00);
    chk("clear_3q", 32'(rd < 32'h8), 32'h1);
    rdchk("late_3q", ADDR_STS, 8'h04);
    $display("test window three quarters done");
    test_done();
  end

  // Longest path is about 31k cycles of overflow waits plus bus traffic
  initial begin
    repeat (90000) @(posedge ref_clk_i);
    fail_count++;
    test_done();
  end
endmodule // wdw_top_tb_top
`default_nettype wire
